/* shared/tmr_defs.svh */
// constants of the 16-bit timer core: mode codes, output actions, divider factors
// assumes inclusion from the package and the design files only
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// ----------------------------------------
// counter limits and reset values
// ----------------------------------------
`define TMR_COUNT_MAX 16'hFFFF
`define TMR_COUNT_BOTTOM 16'h0000
`define TMR_COUNT_RESET 16'h0000
`define TMR_STATE_RESET 1'h0

// ----------------------------------------
// waveform mode select codes
// ----------------------------------------
`define TMR_WGM_NORMAL 4'h0
`define TMR_WGM_CTC_CHA 4'h4
`define TMR_WGM_CTC_CAP 4'hC

// ----------------------------------------
// compare output mode codes
// ----------------------------------------
`define TMR_COM_OFF 2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_CLEAR 2'h2
`define TMR_COM_SET 2'h3

// ----------------------------------------
// clock select codes and divider factors
// ----------------------------------------
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_DIV16 3'h6
`define TMR_CS_DIV32 3'h7
`define TMR_PRE_WIDTH 10
`define TMR_MASK_DIV8 10'h007
`define TMR_MASK_DIV16 10'h00F
`define TMR_MASK_DIV32 10'h01F
`define TMR_MASK_DIV64 10'h03F
`define TMR_MASK_DIV256 10'h0FF
`define TMR_MASK_DIV1024 10'h3FF

`endif

/* shared/tmr_pkg.sv */
// types shared by the timer core and its two leaf modules
// assumes tmr_defs.svh on the include path
`include "tmr_defs.svh"

package tmr_pkg;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef logic [15:0] tmr_count_t;

  typedef enum logic [1:0] {
    tmr_com_off = `TMR_COM_OFF,
    tmr_com_toggle = `TMR_COM_TOGGLE,
    tmr_com_clear = `TMR_COM_CLEAR,
    tmr_com_set = `TMR_COM_SET
  } tmr_com_t;

  typedef enum logic [2:0] {
    tmr_cs_stop = `TMR_CS_STOP,
    tmr_cs_div1 = `TMR_CS_DIV1,
    tmr_cs_div8 = `TMR_CS_DIV8,
    tmr_cs_div64 = `TMR_CS_DIV64,
    tmr_cs_div256 = `TMR_CS_DIV256,
    tmr_cs_div1024 = `TMR_CS_DIV1024,
    tmr_cs_div16 = `TMR_CS_DIV16,
    tmr_cs_div32 = `TMR_CS_DIV32
  } tmr_cs_t;

endpackage

/* hw/tmr_prescaler.sv */
// clock prescaler: one-cycle timer tick enable from the system clock
// assumes a single clock domain; clock select is a level input
`include "tmr_defs.svh"

module tmr_prescaler #(
  parameter bit EXTENDED_FACTORS = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [2:0] i_clock_select,
  output logic o_tick
);

  // ----------------------------------------
  // free-running divider
  // ----------------------------------------
  // shared by all factors, so a factor change takes effect without a restart
  logic [`TMR_PRE_WIDTH-1:0] div_reg;
  logic [`TMR_PRE_WIDTH-1:0] mask;
  logic tick_en;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + `TMR_PRE_WIDTH'(1);
    end
  end

  // ----------------------------------------
  // factor selection
  // ----------------------------------------
  // selectable factors
  always_comb begin
    mask = '0;
    tick_en = 1'b1;
    case (tmr_pkg::tmr_cs_t'(i_clock_select))
      tmr_pkg::tmr_cs_stop: tick_en = 1'b0;
      tmr_pkg::tmr_cs_div1: mask = '0;
      tmr_pkg::tmr_cs_div8: mask = `TMR_MASK_DIV8;
      tmr_pkg::tmr_cs_div64: mask = `TMR_MASK_DIV64;
      tmr_pkg::tmr_cs_div256: mask = `TMR_MASK_DIV256;
      tmr_pkg::tmr_cs_div1024: mask = `TMR_MASK_DIV1024;
      tmr_pkg::tmr_cs_div16: begin
        mask = `TMR_MASK_DIV16;
        tick_en = EXTENDED_FACTORS;
      end
      tmr_pkg::tmr_cs_div32: begin
        mask = `TMR_MASK_DIV32;
        tick_en = EXTENDED_FACTORS;
      end
      default: tick_en = 1'b0;
    endcase
  end

  assign o_tick = tick_en && ((div_reg & mask) == mask);

endmodule

/* hw/tmr_oc_unit.sv */
// compare output state of one channel: set, clear or toggle on match or force
// assumes match and force are one-cycle pulses in the system clock domain
`include "tmr_defs.svh"

module tmr_oc_unit (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [1:0] i_compare_output_mode,
  input wire logic i_pwm_mode,
  input wire logic i_match,
  input wire logic i_force,
  output logic o_state
);

  logic state_reg;
  logic state_next;
  logic apply;

  assign apply = i_match || (i_force && !i_pwm_mode);

  // ----------------------------------------
  // action selection
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    if (apply) begin
      unique case (tmr_pkg::tmr_com_t'(i_compare_output_mode))
        tmr_pkg::tmr_com_off: state_next = state_reg;
        tmr_pkg::tmr_com_toggle: state_next = !state_reg;
        tmr_pkg::tmr_com_clear: state_next = i_pwm_mode;
        tmr_pkg::tmr_com_set: state_next = !i_pwm_mode;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= `TMR_STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_state = state_reg;

endmodule

/* hw/tmr_core.sv */
// 16-bit timer core: normal and clear-on-match counting, flags, compare outputs
// assumes control bits and write strobes are synchronous to i_clk_sys
//
// Overview of operation
// - Compare output mode zero leaves the channel's output state untouched at matches.
// - A new compare output mode acts at the first match after it is written.
// - Force strobe applies the selected action at once, outside pwm modes only.
// - Counting follows waveform mode only; output mode touches only the pin.
// - Non-pwm: set, clear or toggle on match; pwm: polarity choice.
// - Normal mode counts up always and rolls from FFFF to 0000.
// - Normal mode sets overflow as count becomes zero; counting never clears it.
// - Entering the overflow service clears the overflow flag.
// - Normal mode accepts a new count value at any time.
// - Clear-on-match clears count at channel A value (4) or capture top (12).
// - Clear-on-match top sets channel A flag or capture flag, per top source.
// - Top is not buffered; a top below count wraps through FFFF first.
// - Clear-on-match with channel A mode 1 toggles channel A at every match.
// - Channel A output reaches the pin only when its direction bit is 1.
// - Prescaler gives 1, 8, 64, 256, 1024, plus 16 and 32 optionally.
// - Toggle period is one plus compare value timer clocks; zero toggles each tick.
// - Clear-on-match sets overflow as count passes from FFFF to 0000.
// - Forced compare updates output only: no flag, no counter clear.
// - A count write suppresses all matches in the next timer clock cycle.
// - System reset clears every compare output state to 0.
// - Nonzero output mode replaces the port value; direction stays with the port.
`include "tmr_defs.svh"

module tmr_core #(
  parameter int NUM_CH = 2,
  parameter bit EXTENDED_FACTORS = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [3:0] i_waveform_mode_select,
  input wire logic [2:0] i_clock_select,
  input wire logic i_count_write,
  input wire logic [15:0] i_count_write_data,
  input wire logic [NUM_CH*16-1:0] i_channel_compare_value,
  input wire logic [15:0] i_capture_top_register,
  input wire logic [NUM_CH*2-1:0] i_compare_output_mode,
  input wire logic [NUM_CH-1:0] i_force_compare_strobe,
  input wire logic i_overflow_service,
  input wire logic [NUM_CH-1:0] i_compare_flag_clear,
  input wire logic i_capture_flag_clear,
  input wire logic [NUM_CH-1:0] i_pin_direction,
  input wire logic [NUM_CH-1:0] i_port_output,
  output logic [15:0] o_count_value,
  output logic o_overflow_flag,
  output logic [NUM_CH-1:0] o_channel_compare_flag,
  output logic o_capture_flag,
  output logic [NUM_CH-1:0] o_compare_output_state,
  output logic [NUM_CH-1:0] o_pin_out,
  output logic [NUM_CH-1:0] o_pin_oe
);

  // ----------------------------------------
  // internal signals
  // ----------------------------------------
  tmr_pkg::tmr_count_t count_reg;
  tmr_pkg::tmr_count_t count_next;
  tmr_pkg::tmr_count_t top_value;
  logic tick;
  logic block_reg;
  logic mode_normal;
  logic mode_ctc_cha;
  logic mode_ctc_cap;
  logic mode_ctc;
  logic mode_pwm;
  logic top_hit;
  logic wrap_hit;
  logic overflow_reg;
  logic capture_reg;
  logic [NUM_CH-1:0] match;
  logic [NUM_CH-1:0] flag_reg;
  logic [NUM_CH-1:0] state;
  logic [NUM_CH-1:0] pin_out_reg;
  logic [NUM_CH-1:0] pin_oe_reg;

  // ----------------------------------------
  // timer clock
  // ----------------------------------------
  tmr_prescaler #(
    .EXTENDED_FACTORS(EXTENDED_FACTORS)
  ) u_prescaler (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_clock_select(i_clock_select),
    .o_tick(tick)
  );

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // codes outside normal and clear-on-match are treated as pwm for the
  // output logic; their counting sequences are not built here and they
  // run as a free counter, so do not rely on them
  // sequence from waveform mode
  assign mode_normal = (i_waveform_mode_select == `TMR_WGM_NORMAL);
  assign mode_ctc_cha = (i_waveform_mode_select == `TMR_WGM_CTC_CHA);
  assign mode_ctc_cap = (i_waveform_mode_select == `TMR_WGM_CTC_CAP);
  assign mode_ctc = mode_ctc_cha || mode_ctc_cap;
  assign mode_pwm = !(mode_normal || mode_ctc);

  assign top_value = mode_ctc_cap ? i_capture_top_register : i_channel_compare_value[15:0];

  // ----------------------------------------
  // match suppression after a count write
  // ----------------------------------------
  // held until a timer tick arrives, so it also covers a stopped timer
  // write blocks next tick
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      block_reg <= 1'b0;
    end else if (i_count_write) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // compare and top detection
  // ----------------------------------------
  // equality only: a top written below the count is passed by, and the
  // counter must wrap through FFFF before it can match again
  // unbuffered top compare
  assign top_hit = tick && !block_reg && mode_ctc && (count_reg == top_value);
  assign wrap_hit = tick && (count_reg == `TMR_COUNT_MAX);

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      assign match[ch] = tick && !block_reg &&
                         (count_reg == i_channel_compare_value[ch*16 +: 16]);

      tmr_oc_unit u_oc (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_compare_output_mode(i_compare_output_mode[ch*2 +: 2]),
        .i_pwm_mode(mode_pwm),
        .i_match(match[ch]),
        .i_force(i_force_compare_strobe[ch]),
        .o_state(state[ch])
      );

      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          flag_reg[ch] <= 1'b0;
        end else if (match[ch]) begin
          flag_reg[ch] <= 1'b1;
        end else if (i_compare_flag_clear[ch]) begin
          flag_reg[ch] <= 1'b0;
        end
      end

      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          pin_out_reg[ch] <= 1'b0;
          pin_oe_reg[ch] <= 1'b0;
        end else begin
          pin_out_reg[ch] <= (i_compare_output_mode[ch*2 +: 2] != `TMR_COM_OFF) ?
                             state[ch] : i_port_output[ch];
          pin_oe_reg[ch] <= i_pin_direction[ch];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // counter
  // ----------------------------------------
  always_comb begin
    count_next = count_reg;
    if (i_count_write) begin
      count_next = i_count_write_data;
    end else if (tick) begin
      if (top_hit) begin
        count_next = `TMR_COUNT_BOTTOM;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= `TMR_COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // ----------------------------------------
  // overflow and capture flags
  // ----------------------------------------
  // a count write that lands on the wrap tick wins over the wrap, so no
  // overflow is seen for a value that never became zero by counting
  // overflow as count wraps
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overflow_reg <= 1'b0;
    end else if (wrap_hit && !i_count_write) begin
      overflow_reg <= 1'b1;
    end else if (i_overflow_service) begin
      overflow_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      capture_reg <= 1'b0;
    end else if (top_hit && mode_ctc_cap) begin
      capture_reg <= 1'b1;
    end else if (i_capture_flag_clear) begin
      capture_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // pin outputs lag the state by one clock so all outputs leave flip-flops
  assign o_count_value = count_reg;
  assign o_overflow_flag = overflow_reg;
  assign o_channel_compare_flag = flag_reg;
  assign o_capture_flag = capture_reg;
  assign o_compare_output_state = state;
  assign o_pin_out = pin_out_reg;
  assign o_pin_oe = pin_oe_reg;

endmodule

/* sim/tmr_core_sva.sv */
// checker for tmr_core: counter steps, flags and pin drive
// assumes binding to tmr_core, one clock, async active-low reset
module tmr_core_sva #(
  parameter int NUM_CH = 2
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [3:0] i_waveform_mode_select,
  input wire logic i_count_write,
  input wire logic [15:0] i_count_write_data,
  input wire logic [NUM_CH*16-1:0] i_channel_compare_value,
  input wire logic [15:0] i_capture_top_register,
  input wire logic [NUM_CH*2-1:0] i_compare_output_mode,
  input wire logic i_overflow_service,
  input wire logic [NUM_CH-1:0] i_pin_direction,
  input wire logic [NUM_CH-1:0] i_port_output,
  input wire logic [15:0] o_count_value,
  input wire logic o_overflow_flag,
  input wire logic [NUM_CH-1:0] o_channel_compare_flag,
  input wire logic o_capture_flag,
  input wire logic [NUM_CH-1:0] o_compare_output_state,
  input wire logic [NUM_CH-1:0] o_pin_out,
  input wire logic [NUM_CH-1:0] o_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_wrap;
    $past(o_count_value) == 16'hFFFF && o_count_value == 16'h0000;
  endsequence
  sequence s_load;
    i_count_write ##1 o_count_value == $past(i_count_write_data);
  endsequence
  a_ovf_at_wrap: assert property ($rose(o_overflow_flag) |-> s_wrap)
    else $error("overflow flag rose away from the wrap");
  a_ovf_sticky: assert property ($fell(o_overflow_flag) |-> $past(i_overflow_service))
    else $error("overflow flag fell without service");
  a_write_load: assert property (i_count_write |-> s_load)
    else $error("count write not loaded");
  a_count_step: assert property (
    !$past(i_count_write) && $past(i_waveform_mode_select) == 4'h0 |->
    o_count_value == $past(o_count_value) ||
    o_count_value == 16'($past(o_count_value) + 16'h0001))
    else $error("normal mode count did not step by one");
  a_ctc_clear: assert property (
    $past(i_waveform_mode_select) == 4'h4 && !$past(i_count_write) &&
    o_count_value == 16'h0000 && $past(o_count_value) != 16'h0000 |->
    $past(o_count_value) == $past(i_channel_compare_value[15:0]) ||
    $past(o_count_value) == 16'hFFFF)
    else $error("count cleared off top");
  a_flag_match: assert property ($rose(o_channel_compare_flag[0]) |->
    $past(o_count_value) == $past(i_channel_compare_value[15:0]))
    else $error("compare flag without equal count");
  a_cap_flag: assert property ($rose(o_capture_flag) |->
    $past(i_waveform_mode_select) == 4'hC &&
    $past(o_count_value) == $past(i_capture_top_register))
    else $error("capture flag without top hit");
  a_off_quiet: assert property (
    $past(i_compare_output_mode[1:0]) == 2'h0 &&
    $past(i_compare_output_mode[1:0], 2) == 2'h0 |-> $stable(o_compare_output_state[0]))
    else $error("state moved with mode off");
  a_pin_drive: assert property (
    o_pin_oe[0] == $past(i_pin_direction[0]) && o_pin_out[0] ==
    ($past(i_compare_output_mode[1:0]) != 2'h0 ?
    $past(o_compare_output_state[0]) : $past(i_port_output[0])))
    else $error("pin drive wrong");
endmodule
bind tmr_core tmr_core_sva #(.NUM_CH(NUM_CH)) tmr_core_sva_inst (.i_clk_sys, .i_rst_n,
  .i_waveform_mode_select, .i_count_write, .i_count_write_data, .i_channel_compare_value,
  .i_capture_top_register, .i_compare_output_mode, .i_overflow_service, .i_pin_direction,
  .i_port_output, .o_count_value, .o_overflow_flag, .o_channel_compare_flag,
  .o_capture_flag, .o_compare_output_state, .o_pin_out, .o_pin_oe);

/* sim/tmr_core_tb.sv */
// self-checking bench for tmr_core, one task per scenario
// assumes tmr_core with two channels; inputs change at the falling edge
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp); end end
module tmr_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys, i_rst_n, i_count_write, i_overflow_service, i_capture_flag_clear;
  logic [3:0] i_waveform_mode_select, i_compare_output_mode;
  logic [2:0] i_clock_select;
  logic [15:0] i_count_write_data, i_capture_top_register, o_count_value;
  logic [31:0] i_channel_compare_value;
  logic [1:0] i_force_compare_strobe, i_compare_flag_clear, i_pin_direction, i_port_output;
  logic [1:0] o_channel_compare_flag, o_compare_output_state, o_pin_out, o_pin_oe;
  logic o_overflow_flag, o_capture_flag;
  int n_errors = 0;
  int checks = 0;
  tmr_core #(.NUM_CH(2), .EXTENDED_FACTORS(1'b1)) tmr_core_inst (.i_clk_sys, .i_rst_n,
    .i_waveform_mode_select, .i_clock_select, .i_count_write, .i_count_write_data,
    .i_channel_compare_value, .i_capture_top_register, .i_compare_output_mode,
    .i_force_compare_strobe, .i_overflow_service, .i_compare_flag_clear,
    .i_capture_flag_clear, .i_pin_direction, .i_port_output, .o_count_value,
    .o_overflow_flag, .o_channel_compare_flag, .o_capture_flag, .o_compare_output_state,
    .o_pin_out, .o_pin_oe);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    i_clk_sys = 1'h0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic wr(input logic [15:0] d);
    i_count_write = 1'h1;
    i_count_write_data = d;
    cyc(1);
    i_count_write = 1'h0;
  endtask
  task automatic clr_flags;
    i_compare_flag_clear = 2'h3;
    i_capture_flag_clear = 1'h1;
    cyc(1);
    i_compare_flag_clear = 2'h0;
    i_capture_flag_clear = 1'h0;
  endtask
  // cycles until count (sel 0) or channel A state (sel 1) changes; bounded
  task automatic chg(input bit sel, output int k);
    logic [15:0] c;
    c = sel ? {15'h0, o_compare_output_state[0]} : o_count_value;
    k = 0;
    while ((sel ? {15'h0, o_compare_output_state[0]} : o_count_value) === c && k < 2100) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    `CHK(o_compare_output_state, 2'h0)
    `CHK({o_count_value, o_overflow_flag, o_capture_flag}, 18'h00000)
    $display("t_reset done");
  endtask
  task automatic t_wrap;
    i_clock_select = 3'h1;
    wr(16'hFFFE);
    // load, roll over, overflow at zero
    `CHK(o_count_value, 16'hFFFE)
    cyc(1);
    `CHK({o_count_value, o_overflow_flag}, 17'h1FFFE)
    cyc(1);
    `CHK({o_count_value, o_overflow_flag}, 17'h00001)
    cyc(3);
    `CHK(o_overflow_flag, 1'h1)
    i_overflow_service = 1'h1;
    cyc(1);
    i_overflow_service = 1'h0;
    `CHK(o_overflow_flag, 1'h0)
    $display("t_wrap done");
  endtask
  task automatic t_prescale;
    int n[7] = '{1, 8, 64, 256, 1024, 16, 32};
    int k;
    for (int i = 0; i < 7; i++) begin
      i_clock_select = 3'(i + 1);
      chg(1'b0, k);
      chg(1'b0, k);
      `CHK(k, n[i])
    end
    i_clock_select = 3'h0;
    $display("t_prescale done");
  endtask
  task automatic t_ctc(input logic [3:0] w, input logic [15:0] top);
    int k;
    i_waveform_mode_select = w;
    i_channel_compare_value[15:0] = top;
    i_capture_top_register = top;
    i_compare_output_mode[1:0] = 2'h1;
    // preload max: a zero top blocked by the write would need a full wrap
    wr(16'hFFFF);
    clr_flags();
    i_clock_select = 3'h1;
    chg(1'b1, k);
    chg(1'b1, k);
    // toggle every top plus one ticks
    `CHK(k, int'(top) + 1)
    `CHK(o_capture_flag, (w == 4'hC))
    if (w == 4'h4) `CHK(o_channel_compare_flag[0], 1'h1)
    i_clock_select = 3'h0;
    `CHK(o_overflow_flag, 1'h1)
    i_overflow_service = 1'h1;
    cyc(1);
    i_overflow_service = 1'h0;
    $display("t_ctc done");
  endtask
  task automatic t_ctc_wrap;
    i_waveform_mode_select = 4'h4;
    i_channel_compare_value[15:0] = 16'h0005;
    wr(16'hFFF0);
    i_clock_select = 3'h1;
    cyc(15);
    `CHK({o_count_value, o_overflow_flag}, 17'h1FFFE)
    cyc(1);
    // top below count wraps through max first
    `CHK({o_count_value, o_overflow_flag}, 17'h00001)
    cyc(6);
    `CHK(o_count_value, 16'h0000)
    i_clock_select = 3'h0;
    $display("t_ctc_wrap done");
  endtask
  task automatic t_force;
    logic [1:0] m[4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    logic e[4] = '{1'h1, 1'h0, 1'h1, 1'h1};
    logic [15:0] c;
    i_waveform_mode_select = 4'h0;
    clr_flags();
    c = o_count_value;
    for (int i = 0; i < 4; i++) begin
      i_compare_output_mode[1:0] = m[i];
      i_force_compare_strobe = 2'h1;
      cyc(1);
      i_force_compare_strobe = 2'h0;
      `CHK(o_compare_output_state[0], e[i])
      cyc(1);
    end
    `CHK({o_channel_compare_flag[0], o_count_value}, {1'h0, c})
    $display("t_force done");
  endtask
  task automatic t_block;
    i_channel_compare_value[15:0] = 16'h0010;
    clr_flags();
    wr(16'h0010);
    i_clock_select = 3'h1;
    cyc(4);
    `CHK(o_channel_compare_flag[0], 1'h0)
    wr(16'h000E);
    cyc(4);
    `CHK(o_channel_compare_flag[0], 1'h1)
    i_clock_select = 3'h0;
    $display("t_block done");
  endtask
  task automatic t_pins;
    i_compare_output_mode = 4'h0;
    i_pin_direction = 2'h3;
    i_port_output = 2'h3;
    cyc(2);
    // port value passes while mode off
    `CHK({o_pin_out, o_pin_oe}, 4'hF)
    i_compare_output_mode[1:0] = 2'h2;
    i_port_output = 2'h0;
    cyc(2);
    // state overrides port; new mode waits for a match
    `CHK({o_pin_out, o_compare_output_state[0]}, 3'h3)
    i_pin_direction = 2'h0;
    cyc(2);
    `CHK(o_pin_oe, 2'h0)
    $display("t_pins done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    {i_rst_n, i_count_write, i_overflow_service, i_capture_flag_clear} = '0;
    {i_waveform_mode_select, i_clock_select, i_count_write_data, i_channel_compare_value,
      i_capture_top_register, i_compare_output_mode, i_force_compare_strobe,
      i_compare_flag_clear, i_pin_direction, i_port_output} = '0;
    cyc(5);
    i_rst_n = 1'h1;
    t_reset();
    t_wrap();
    t_prescale();
    t_ctc(4'h4, 16'h0002);
    t_ctc(4'h4, 16'h0000);
    t_ctc(4'hC, 16'h0003);
    t_ctc_wrap();
    t_force();
    t_block();
    t_pins();
    conclude();
  end
  // about 2200 cycles expected; generous margin
  initial begin
    cyc(20000);
    n_errors++;
    conclude();
  end
endmodule
